/* File: spp_pkg.sv */
// Package of constants for the six-pin port
package spp_pkg;
  localparam int SPP_PINS = 6;
  // Register offsets
  localparam logic [3:0] SPP_ADDR_DATA = 4'h0;
  localparam logic [3:0] SPP_ADDR_DIR = 4'h1;
  localparam logic [3:0] SPP_ADDR_PULLUP = 4'h2;
  localparam logic [3:0] SPP_ADDR_PULLDOWN = 4'h3;
  localparam logic [3:0] SPP_ADDR_ODRAIN = 4'h4;
  localparam logic [3:0] SPP_ADDR_LCSEL = 4'h5;
  localparam logic [3:0] SPP_ADDR_INT_FLAG_REG = 4'h6;
  localparam logic [3:0] SPP_ADDR_INT_ENABLE_REG = 4'h7;
  localparam logic [3:0] SPP_ADDR_POWER_CTRL_REG = 4'h8;
  localparam logic [3:0] SPP_ADDR_PCON2 = 4'h9;
  localparam logic [3:0] SPP_ADDR_IR_CTRL_REG = 4'ha;
  localparam logic [3:0] SPP_ADDR_TIMER1_CTRL_REG_1 = 4'hb;
  localparam logic [3:0] SPP_ADDR_BZCR = 4'hc;
  localparam logic [3:0] SPP_ADDR_TIMER0_MODE_REG = 4'hd;
  localparam logic [3:0] SPP_ADDR_T1CR2 = 4'he;
  localparam logic [3:0] SPP_ADDR_MISC = 4'hf;
  // Field positions
  localparam int SPP_BIT_PORT_CHANGE_FLAG = 1;
  localparam int SPP_BIT_EXTIF = 2;
  localparam int SPP_BIT_PORT_CHANGE_INT_ENABLE = 1;
  localparam int SPP_BIT_EXTIE = 2;
  localparam int SPP_BIT_GIE = 7;
  localparam int SPP_BIT_EIS = 6;
  localparam int SPP_BIT_IR_CARRIER_ENABLE = 0;
  localparam int SPP_BIT_IRPOL = 2;
  localparam int SPP_BIT_PWMEN = 7;
  localparam int SPP_BIT_BZEN = 7;
  localparam int SPP_BIT_TIMER0_CLOCK_SOURCE_SEL = 5;
  localparam int SPP_BIT_T0LCK = 7;
  localparam int SPP_BIT_TIMER1_CLOCK_SOURCE_SEL = 5;
  localparam int SPP_PD_LSB = 4;
  // Misc register bits: edge select at 0, read type pin 0 at 1, pins 5..1 at [7:3], bit 2 unused
  localparam int SPP_BIT_EDGE = 0;
  // Reset values
  localparam logic [7:0] SPP_RST_DATA = 8'h00;
  localparam logic [7:0] SPP_RST_DIR = 8'h3f;
  localparam logic [7:0] SPP_RST_ZERO = 8'h00;
  // Operating modes
  localparam logic [1:0] SPP_MODE_NORMAL = 2'h0;
  localparam logic [1:0] SPP_MODE_STANDBY = 2'h2;
endpackage

/* File: spp_sense_if.sv */
// Interface carrying pad samples and change events between port modules
`timescale 1ns/1ps
interface spp_sense_if;
  logic [5:0] raw;
  logic [5:0] level;
  logic [5:0] changed;
  logic edge_seen;
  logic edge_fall;
  modport det(input raw, input edge_fall, output level, output changed, output edge_seen);
  modport use_side(output raw, output edge_fall, input level, input changed, input edge_seen);
endinterface

/* File: spp_change_det.sv */
// Pad synchroniser and level-change and edge detector
`timescale 1ns/1ps
module spp_change_det
  import spp_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Sense carrier
  spp_sense_if.det sense
);
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] prev;
    logic [2:0] primed;
  } spp_det_s;
  spp_det_s st;
  spp_det_s next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = sense.raw;
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
    // Hold off compares until prev holds a real pad sample
    next_st.primed = {st.primed[1:0], 1'b1};
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sense.level = st.s2;
  // Current sample against previous one
  assign sense.changed = st.primed[2] ? (st.s2 ^ st.prev) : 6'h00;
  assign sense.edge_seen = st.primed[2] &&
    (sense.edge_fall ? (st.prev[0] && !st.s2[0]) : (!st.prev[0] && st.s2[0]));
endmodule

/* File: spp_port.sv */
// Six-pin port with direction, pulls, open drain, change detect and function mux
`timescale 1ns/1ps
// Functional notes
// - Six pins read and written via data
// - Direction bit per pin selects input/output
// - Pull-up per input pin
// - Pull-down bits 7..4 for pins 3..0
// - Open drain select; pin 3 always
// - Selected pin change sets port flag
// - Request needs port or ext enable, and global enable
// - Ext interrupt select makes pin 0 input
// - Ext interrupt overrides pin 0 change detect
// - Edge select picks pin 0 trigger
// - IR enable puts carrier on pin 1
// - Pin 3 low resets when enabled
// - Pin 4 shows instruction clock in Normal/Standby
// - Pin 2 feeds timer count clocks
// - Pin 2 carries PWM when selected
// - Pin 2 carries buzzer when selected
// - Read type picks pad or latch
// - Wake enable pins raise wake set
// - PWM enable forces pin 2 output when buzzer option is clear
// - IR enable forces pin 1 output
module spp_port
  import spp_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Pads
  input wire logic [5:0] pad_i,
  output logic [5:0] pad_o,
  output logic [5:0] pad_oe_n_o,
  output logic [5:0] pullup_enable_n_o,
  output logic [3:0] pulldown_en_o,
  // Configuration options
  input wire logic reset_pad_enable_i,
  input wire logic pin4_clock_out_opt_i,
  input wire logic pin2_buzzer_opt_i,
  input wire logic [1:0] op_mode_i,
  // Alternate function sources
  input wire logic ir_carrier_data_i,
  input wire logic pwm_data_i,
  input wire logic buzzer_data_i,
  input wire logic instr_clock_i,
  // System outputs
  output logic reset_pad_input_n_o,
  output logic timer0_count_clock_o,
  output logic timer1_count_clock_o,
  output logic set_port_change_flag_o,
  output logic ext_int_signal_o,
  output logic int_req_o
);
  typedef struct packed {
    logic [5:0] port_data_reg;
    logic [5:0] direction_reg;
    logic [5:0] pullup_ctrl_reg;
    logic [3:0] pulldown_ctrl_reg;
    logic [5:0] open_drain_ctrl_reg;
    logic [5:0] level_change_select_reg;
    logic [5:0] read_type_reg;
    logic [5:0] wakeup_enable;
    logic port_change_flag;
    logic ext_int_flag;
    logic port_change_int_enable;
    logic ext_int_enable;
    logic ext_int_select;
    logic global_int_enable;
    logic ext_int_edge_select;
    logic ir_carrier_enable;
    logic ir_polarity;
    logic pwm_output_enable;
    logic buzzer_enable;
    logic timer0_clock_source_sel;
    logic timer0_low_clock_sel;
    logic timer1_clock_source_sel;
    logic [7:0] rdata;
    logic [5:0] pad_out;
    logic [5:0] oe_n;
    logic wake;
  } spp_port_s;

  spp_port_s st;
  spp_port_s next_st;
  spp_sense_if sense();

  logic [5:0] is_out;
  logic [5:0] drive_val;
  logic [5:0] od_mask;
  logic [5:0] watch;
  logic [5:0] read_val;
  logic pwm_buzzer_enable;
  logic pwm_buzzer_data;
  logic clk_out_on;

  assign sense.raw = pad_i;
  assign sense.edge_fall = st.ext_int_edge_select;

  spp_change_det u_det (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .sense(sense)
  );

  always_comb begin
    pwm_buzzer_enable = pin2_buzzer_opt_i ? st.buzzer_enable : st.pwm_output_enable;
    pwm_buzzer_data = pin2_buzzer_opt_i ? buzzer_data_i : pwm_data_i;
    clk_out_on = pin4_clock_out_opt_i &&
      (op_mode_i == SPP_MODE_NORMAL || op_mode_i == SPP_MODE_STANDBY);
    is_out = ~st.direction_reg;
    drive_val = st.port_data_reg;
    if (st.ext_int_select) begin
      is_out[0] = 1'b0;
    end
    if (st.ir_carrier_enable) begin
      is_out[1] = 1'b1;
      drive_val[1] = ir_carrier_data_i &
        (st.ir_polarity ? ~st.port_data_reg[1] : st.port_data_reg[1]);
    end
    if (pwm_buzzer_enable) begin
      is_out[2] = 1'b1;
      drive_val[2] = pwm_buzzer_data;
    end
    if (clk_out_on) begin
      is_out[4] = 1'b1;
      drive_val[4] = instr_clock_i;
    end
    if (reset_pad_enable_i) begin
      is_out[3] = 1'b0;
    end
    od_mask = st.open_drain_ctrl_reg;
    od_mask[3] = 1'b1;
    watch = st.level_change_select_reg;
    if (st.ext_int_select) begin
      watch[0] = 1'b0;
    end
    for (int i = 0; i < SPP_PINS; i++) begin
      read_val[i] = st.read_type_reg[i] ? st.port_data_reg[i] : sense.level[i];
    end
  end

  always_comb begin
    next_st = st;
    // Open drain drives only the low level
    for (int i = 0; i < SPP_PINS; i++) begin
      next_st.pad_out[i] = drive_val[i];
      next_st.oe_n[i] = !(is_out[i] && !(od_mask[i] && drive_val[i]));
    end
    // Pin 0 wake follows its change detect, off under external interrupt
    next_st.wake = |(sense.changed & st.wakeup_enable &
      {5'h1f, !st.ext_int_select});
    next_st.rdata = 8'h00;
    if (wr_i) begin
      unique case (addr_i)
        SPP_ADDR_DATA: next_st.port_data_reg = wdata_i[5:0];
        SPP_ADDR_DIR: next_st.direction_reg = wdata_i[5:0];
        SPP_ADDR_PULLUP: next_st.pullup_ctrl_reg = wdata_i[5:0];
        SPP_ADDR_PULLDOWN: next_st.pulldown_ctrl_reg = wdata_i[7:SPP_PD_LSB];
        SPP_ADDR_ODRAIN: next_st.open_drain_ctrl_reg = wdata_i[5:0];
        SPP_ADDR_LCSEL: next_st.level_change_select_reg = wdata_i[5:0];
        SPP_ADDR_INT_FLAG_REG: begin
          next_st.port_change_flag = st.port_change_flag & wdata_i[SPP_BIT_PORT_CHANGE_FLAG];
          next_st.ext_int_flag = st.ext_int_flag & wdata_i[SPP_BIT_EXTIF];
        end
        SPP_ADDR_INT_ENABLE_REG: begin
          next_st.port_change_int_enable = wdata_i[SPP_BIT_PORT_CHANGE_INT_ENABLE];
          next_st.ext_int_enable = wdata_i[SPP_BIT_EXTIE];
        end
        SPP_ADDR_POWER_CTRL_REG: next_st.ext_int_select = wdata_i[SPP_BIT_EIS];
        SPP_ADDR_PCON2: next_st.global_int_enable = wdata_i[SPP_BIT_GIE];
        SPP_ADDR_IR_CTRL_REG: begin
          next_st.ir_carrier_enable = wdata_i[SPP_BIT_IR_CARRIER_ENABLE];
          next_st.ir_polarity = wdata_i[SPP_BIT_IRPOL];
        end
        SPP_ADDR_TIMER1_CTRL_REG_1: next_st.pwm_output_enable = wdata_i[SPP_BIT_PWMEN];
        SPP_ADDR_BZCR: next_st.buzzer_enable = wdata_i[SPP_BIT_BZEN];
        SPP_ADDR_TIMER0_MODE_REG: begin
          next_st.timer0_clock_source_sel = wdata_i[SPP_BIT_TIMER0_CLOCK_SOURCE_SEL];
          next_st.timer0_low_clock_sel = wdata_i[SPP_BIT_T0LCK];
        end
        SPP_ADDR_T1CR2: next_st.timer1_clock_source_sel = wdata_i[SPP_BIT_TIMER1_CLOCK_SOURCE_SEL];
        SPP_ADDR_MISC: next_st.ext_int_edge_select = wdata_i[SPP_BIT_EDGE];
        default: next_st.read_type_reg = st.read_type_reg;
      endcase
    end
    // Read type shares the misc write with edge select; wake enables share the change-select write
    if (wr_i && addr_i == SPP_ADDR_MISC) begin
      next_st.read_type_reg = {wdata_i[7:3], wdata_i[1]};
    end
    if (wr_i && addr_i == SPP_ADDR_LCSEL) begin
      next_st.wakeup_enable = wdata_i[5:0];
    end
    // Hardware set wins over a software clear
    if (|(sense.changed & watch)) begin
      next_st.port_change_flag = 1'b1;
    end
    if (st.ext_int_select && sense.edge_seen) begin
      next_st.ext_int_flag = 1'b1;
    end
    if (rd_i) begin
      unique case (addr_i)
        SPP_ADDR_DATA: next_st.rdata = {2'b00, read_val};
        SPP_ADDR_DIR: next_st.rdata = {2'b00, st.direction_reg};
        SPP_ADDR_PULLUP: next_st.rdata = {2'b00, st.pullup_ctrl_reg};
        SPP_ADDR_PULLDOWN: next_st.rdata = {st.pulldown_ctrl_reg, 4'h0};
        SPP_ADDR_ODRAIN: next_st.rdata = {2'b00, st.open_drain_ctrl_reg};
        SPP_ADDR_LCSEL: next_st.rdata = {2'b00, st.level_change_select_reg};
        SPP_ADDR_INT_FLAG_REG: next_st.rdata = {5'h00, st.ext_int_flag, st.port_change_flag, 1'b0};
        SPP_ADDR_INT_ENABLE_REG: next_st.rdata = {5'h00, st.ext_int_enable,
                                         st.port_change_int_enable, 1'b0};
        SPP_ADDR_POWER_CTRL_REG: next_st.rdata = {1'b0, st.ext_int_select, 6'h00};
        SPP_ADDR_PCON2: next_st.rdata = {st.global_int_enable, 7'h00};
        SPP_ADDR_IR_CTRL_REG: next_st.rdata = {5'h00, st.ir_polarity, 1'b0, st.ir_carrier_enable};
        SPP_ADDR_TIMER1_CTRL_REG_1: next_st.rdata = {st.pwm_output_enable, 7'h00};
        SPP_ADDR_BZCR: next_st.rdata = {st.buzzer_enable, 7'h00};
        SPP_ADDR_TIMER0_MODE_REG: next_st.rdata = {st.timer0_low_clock_sel, 1'b0,
                                         st.timer0_clock_source_sel, 5'h00};
        SPP_ADDR_T1CR2: next_st.rdata = {2'b00, st.timer1_clock_source_sel, 5'h00};
        SPP_ADDR_MISC: next_st.rdata = {st.read_type_reg[5:1], 1'b0,
                                         st.read_type_reg[0], st.ext_int_edge_select};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.port_data_reg <= SPP_RST_DATA[5:0];
      st.direction_reg <= SPP_RST_DIR[5:0];
      st.oe_n <= 6'h3f;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign pad_o = st.pad_out;
  assign pad_oe_n_o = st.oe_n;
  // Pulls off on any pin that is an output, forced ones included
  assign pullup_enable_n_o = ~(st.pullup_ctrl_reg & ~is_out);
  assign pulldown_en_o = st.pulldown_ctrl_reg & ~is_out[3:0];
  assign reset_pad_input_n_o = reset_pad_enable_i ? sense.level[3] : 1'b1;
  assign timer0_count_clock_o = st.timer0_clock_source_sel && !st.timer0_low_clock_sel &&
    sense.level[2];
  assign timer1_count_clock_o = st.timer1_clock_source_sel && sense.level[2];
  assign set_port_change_flag_o = st.wake;
  assign ext_int_signal_o = st.ext_int_flag;
  assign int_req_o = st.global_int_enable &&
    ((st.port_change_int_enable && st.port_change_flag) ||
     (st.ext_int_enable && st.ext_int_flag));
endmodule

/* File: spp_port_asserts.sv */
// Checker for the six-pin port, bound to its ports
`timescale 1ns/1ps
module spp_port_asserts
  import spp_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Pads
  input wire logic [5:0] pad_i,
  input wire logic [5:0] pad_o,
  input wire logic [5:0] pad_oe_n_o,
  input wire logic [5:0] pullup_enable_n_o,
  input wire logic [3:0] pulldown_en_o,
  // System signals
  input wire logic reset_pad_enable_i,
  input wire logic reset_pad_input_n_o,
  input wire logic set_port_change_flag_o,
  input wire logic int_req_o
);
  logic gie_q;
  logic dir3_q;
  logic [5:0] lc_q;
  // Shadows of register bits the relations need
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gie_q <= 1'h0;
      dir3_q <= 1'h1;
      lc_q <= 6'h00;
    end else if (wr_i) begin
      if (addr_i == SPP_ADDR_PCON2) gie_q <= wdata_i[SPP_BIT_GIE];
      if (addr_i == SPP_ADDR_DIR) dir3_q <= wdata_i[3];
      if (addr_i == SPP_ADDR_LCSEL) lc_q <= wdata_i[5:0];
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside answer");
  AST_OD_PIN3: assert property (!pad_oe_n_o[3] |-> !pad_o[3])
    else $error("pin 3 drives high");
  AST_DIR_IN: assert property (
    wr_i && addr_i == SPP_ADDR_DIR && wdata_i[5] |-> ##2 pad_oe_n_o[5])
    else $error("input pin 5 still driven");
  AST_PULLUP_OFF: assert property (
    wr_i && addr_i == SPP_ADDR_DIR && !wdata_i[5] |=> pullup_enable_n_o[5])
    else $error("pull-up on output pin");
  AST_PULLDN3: assert property (
    wr_i && addr_i == SPP_ADDR_PULLDOWN && dir3_q && !reset_pad_enable_i
    |=> pulldown_en_o[3] == $past(wdata_i[7]))
    else $error("pin 3 pull-down wrong");
  AST_INT_GIE: assert property (int_req_o |-> gie_q)
    else $error("request without global enable");
  AST_CHG_SEL: assert property (set_port_change_flag_o
    |-> (lc_q | $past(lc_q) | $past(lc_q, 2) | $past(lc_q, 3)) != 6'h00)
    else $error("change flag with no pin selected");
  AST_RST_OFF: assert property (!reset_pad_enable_i && !$past(reset_pad_enable_i)
    && !$past(reset_pad_enable_i, 2) |-> reset_pad_input_n_o)
    else $error("reset input active while disabled");
  AST_RST_FOLLOW: assert property (
    (reset_pad_enable_i && $stable(pad_i[3]))[*3] |-> reset_pad_input_n_o == pad_i[3])
    else $error("reset input does not follow pin 3");
endmodule
bind spp_port spp_port_asserts u_spp_port_asserts (
  .clock_i(clock_i),
  .rst_n_i(rst_n_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .pad_i(pad_i),
  .pad_o(pad_o),
  .pad_oe_n_o(pad_oe_n_o),
  .pullup_enable_n_o(pullup_enable_n_o),
  .pulldown_en_o(pulldown_en_o),
  .reset_pad_enable_i(reset_pad_enable_i),
  .reset_pad_input_n_o(reset_pad_input_n_o),
  .set_port_change_flag_o(set_port_change_flag_o),
  .int_req_o(int_req_o)
);

/* File: spp_pads_model.sv */
// Board model: resolves pad levels from drive, pulls and external drivers
`timescale 1ns/1ps
module spp_pads_model (
  // Clock
  input wire logic clock_i,
  // From the port
  input wire logic [5:0] drive_i,
  input wire logic [5:0] drive_oe_n_i,
  input wire logic [5:0] pullup_n_i,
  input wire logic [3:0] pulldown_i,
  // Board drivers
  input wire logic [5:0] ext_en_i,
  input wire logic [5:0] ext_val_i,
  // To the port
  output logic [5:0] pad_o
);
  logic [5:0] flt = 6'h2a;
  logic [5:0] pd;
  assign pd = {2'h0, pulldown_i};
  // Undriven line wanders every cycle
  always @(posedge clock_i) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!drive_oe_n_i[i]) pad_o[i] = drive_i[i];
      else if (ext_en_i[i]) pad_o[i] = ext_val_i[i];
      else if (!pullup_n_i[i]) pad_o[i] = 1'h1;
      else if (pd[i]) pad_o[i] = 1'h0;
      else pad_o[i] = flt[i];
    end
  end
endmodule

/* File: spp_port_tb.sv */
// Self-checking testbench of the six-pin port
`timescale 1ns/1ps
module spp_port_tb;
  import spp_pkg::*;
  logic clock_i, rst_n_i, wr_i, rd_i, rpe, bzo, ir_d, pwm_d, bz_d, rd_d, opt4, iclk;
  logic [1:0] opm;
  logic rpn, t0c, t1c, chg, exti, irq;
  logic [3:0] addr_i, pd;
  logic [7:0] wdata_i, rdata_o;
  logic [5:0] pad, pad_o, oe_n, pu_n, ee, ev;
  logic [31:0] seed;
  logic [7:0] expq[$];
  int n_fail, n_checks, pulses, p0;
  spp_port u_spp_port (.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .pad_i(pad), .pad_o, .pad_oe_n_o(oe_n), .pullup_enable_n_o(pu_n), .pulldown_en_o(pd),
    .reset_pad_enable_i(rpe), .pin4_clock_out_opt_i(opt4), .pin2_buzzer_opt_i(bzo),
    .op_mode_i(opm), .ir_carrier_data_i(ir_d), .pwm_data_i(pwm_d),
    .buzzer_data_i(bz_d), .instr_clock_i(iclk), .reset_pad_input_n_o(rpn),
    .timer0_count_clock_o(t0c), .timer1_count_clock_o(t1c), .set_port_change_flag_o(chg),
    .ext_int_signal_o(exti), .int_req_o(irq));
  spp_pads_model u_spp_pads_model (.clock_i, .drive_i(pad_o), .drive_oe_n_i(oe_n),
    .pullup_n_i(pu_n), .pulldown_i(pd), .ext_en_i(ee), .ext_val_i(ev), .pad_o(pad));
  initial begin
    clock_i = 1'h0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic close_out();
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ck(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    expq.push_back(exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clock_i);
    rd_i <= 1'h0;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction
  // Answer watcher: one note per read
  always @(posedge clock_i) rd_d <= rd_i;
  always @(negedge clock_i) begin
    if (rd_d === 1'h1) ck("rdata", rdata_o, expq.pop_front());
    if (chg === 1'h1) pulses++;
  end
  initial begin
    #(50 * 5000);
    n_fail++;
    close_out();
  end
  initial begin
    {rst_n_i, wr_i, rd_i, rpe, bzo, ir_d, pwm_d, bz_d, opt4, iclk} = 10'h000;
    opm = SPP_MODE_NORMAL;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    ee = 6'h00;
    ev = 6'h00;
    seed = 32'h4eab43c3;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'h1;
    rd(SPP_ADDR_DIR, SPP_RST_DIR);
    cyc(0);
    ck("oe_n", {2'h0, oe_n}, 8'h3f);
    @(posedge clock_i);
    ee <= 6'h3f;
    ev <= 6'h3f;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(SPP_ADDR_DATA, seed[7:0]);
      wr(SPP_ADDR_ODRAIN, seed[15:8]);
      wr(SPP_ADDR_DIR, 8'h00);
      cyc(5);
      ck("oe_n", {2'h0, oe_n}, {2'h0, seed[5:0] & (seed[13:8] | 6'h08)});
      rd(SPP_ADDR_DATA, {2'h0, seed[5:0]});
    end
    wr(SPP_ADDR_MISC, 8'hfa);
    ev <= 6'h00;
    cyc(4);
    rd(SPP_ADDR_DATA, {2'h0, seed[5:0]});
    wr(SPP_ADDR_MISC, 8'h00);
    wr(SPP_ADDR_DIR, 8'h3f);
    seed = xs(seed);
    wr(SPP_ADDR_PULLUP, seed[7:0]);
    wr(SPP_ADDR_PULLDOWN, seed[15:8]);
    cyc(0);
    ck("pull_up_n", {2'h0, pu_n}, {2'h0, ~seed[5:0]});
    ck("pull_down", {4'h0, pd}, {4'h0, seed[15:12]});
    wr(SPP_ADDR_DIR, 8'h00);
    cyc(0);
    ck("pull_off_up", {2'h0, pu_n}, 8'h3f);
    ck("pull_off_dn", {4'h0, pd}, 8'h00);
    wr(SPP_ADDR_DIR, 8'h3f);
    wr(SPP_ADDR_LCSEL, 8'h20);
    cyc(4);
    wr(SPP_ADDR_INT_FLAG_REG, 8'h00);
    p0 = pulses;
    ev <= 6'h10;
    cyc(6);
    @(posedge clock_i);
    ev <= 6'h30;
    cyc(6);
    ck("pulses", 8'(pulses - p0), 8'h01);
    rd(SPP_ADDR_INT_FLAG_REG, 8'h02);
    wr(SPP_ADDR_INT_ENABLE_REG, 8'h02);
    cyc(0);
    ck("irq_no_gie", {7'h0, irq}, 8'h00);
    wr(SPP_ADDR_PCON2, 8'h80);
    cyc(0);
    ck("irq", {7'h0, irq}, 8'h01);
    wr(SPP_ADDR_LCSEL, 8'h01);
    wr(SPP_ADDR_POWER_CTRL_REG, 8'h40);
    wr(SPP_ADDR_INT_FLAG_REG, 8'h00);
    p0 = pulses;
    for (int k = 0; k < 2; k++) begin
      wr(SPP_ADDR_MISC, k[7:0]);
      ev <= 6'h31;
      cyc(6);
      ck("ext_rise", {7'h0, exti}, {7'h0, k == 0});
      wr(SPP_ADDR_INT_FLAG_REG, 8'h00);
      ev <= 6'h30;
      cyc(6);
      ck("ext_fall", {7'h0, exti}, {7'h0, k == 1});
      rd(SPP_ADDR_INT_FLAG_REG, {5'h00, k == 1, 2'h0});
      wr(SPP_ADDR_INT_FLAG_REG, 8'h00);
    end
    ck("pin0_chg", 8'(pulses - p0), 8'h00);
    wr(SPP_ADDR_POWER_CTRL_REG, 8'h00);
    rpe <= 1'h1;
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_i);
      ev <= {2'h3, k[0], 3'h0};
      cyc(4);
      ck("rst_in", {7'h0, rpn}, {7'h0, k[0]});
    end
    @(posedge clock_i);
    rpe <= 1'h0;
    wr(SPP_ADDR_ODRAIN, 8'h00);
    wr(SPP_ADDR_DATA, 8'h02);
    wr(SPP_ADDR_IR_CTRL_REG, 8'h01);
    for (int k = 1; k >= 0; k--) begin
      @(posedge clock_i);
      ir_d <= k[0];
      cyc(3);
      ck("ir", {6'h0, oe_n[1], pad_o[1]}, {7'h0, k[0]});
    end
    wr(SPP_ADDR_IR_CTRL_REG, 8'h05);
    ir_d <= 1'h1;
    cyc(3);
    ck("ir_pol", {6'h0, oe_n[1], pad_o[1]}, 8'h00);
    wr(SPP_ADDR_IR_CTRL_REG, 8'h00);
    cyc(2);
    ck("ir_off", {7'h0, oe_n[1]}, 8'h01);
    for (int k = 0; k < 2; k++) begin
      bzo <= k[0];
      pwm_d <= ~k[0];
      bz_d <= k[0];
      wr(k ? SPP_ADDR_BZCR : SPP_ADDR_TIMER1_CTRL_REG_1, 8'h80);
      cyc(3);
      ck("pin2_fn", {6'h0, oe_n[2], pad_o[2]}, 8'h01);
      wr(k ? SPP_ADDR_BZCR : SPP_ADDR_TIMER1_CTRL_REG_1, 8'h00);
    end
    wr(SPP_ADDR_TIMER0_MODE_REG, 8'h20);
    wr(SPP_ADDR_T1CR2, 8'h20);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_i);
      ev <= {3'h6, ~k[0], 2'h0};
      cyc(4);
      ck("tclk", {6'h0, t0c, t1c}, {6'h0, ~k[0], ~k[0]});
    end
    wr(SPP_ADDR_TIMER0_MODE_REG, 8'ha0);
    ev <= 6'h34;
    cyc(4);
    ck("t0_low", {7'h0, t0c}, 8'h00);
    // Modes 0 normal, 1 halt, 2 standby
    for (int k = 0; k < 3; k++) begin
      @(posedge clock_i);
      opt4 <= 1'h1;
      iclk <= 1'h1;
      opm <= k[1:0];
      cyc(2);
      ck("clk_out", {6'h0, oe_n[4], pad_o[4]}, (k == 1) ? 8'h02 : 8'h01);
    end
    close_out();
  end
endmodule
